// *** rtl/cssel_pkg.sv ***
// Package of constants and types for the system clock source selector.
// ****************************************************************
// Register bus geometry
// ****************************************************************
package cssel_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets on the plain register port.
   localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
   localparam logic [3:0] OFS_OSC_TUNE = 4'h1;
   localparam logic [3:0] OFS_SEC_TMR = 4'h2;
   localparam logic [3:0] OFS_PRI_CFG = 4'h3;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int BIT_IDLE_EN = 7;
   localparam int BIT_IFREQ_LO = 4;
   localparam int BIT_PRI_RUN = 3;
   localparam int BIT_INT_STABLE = 2;
   localparam int BIT_SCS_LO = 0;
   localparam int BIT_LF_SRC = 7;
   localparam int BIT_SEC_RUN = 6;
   localparam int BIT_SEC_OSC_EN = 3;

   // Writable bits of the tuning and secondary timer registers.
   localparam logic [7:0] TUNE_WR_MASK = 8'hBF;
   localparam logic [7:0] SEC_WR_MASK = 8'hBF;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [1:0] SCS_RST = 2'h0;
   localparam logic [2:0] IFREQ_RST = 3'h4;
   localparam logic [7:0] TUNE_RST = 8'h00;
   localparam logic [7:0] SEC_RST = 8'h00;

   // Source-select encodings and the lowest internal frequency code.
   localparam logic [1:0] SCS_PRIMARY = 2'h0;
   localparam logic [1:0] SCS_SECONDARY = 2'h1;
   localparam logic [2:0] IFREQ_LOW = 3'h0;

   // ****************************************************************
   // Switch pause, counted in source cycles
   // ****************************************************************
   localparam logic [1:0] OLD_SRC_CYCLES = 2'h2;
   localparam logic [1:0] NEW_SRC_CYCLES = 2'h3;

   // Postscaler counter width; the lowest rate divides by 256.
   localparam int POST_W = 8;

   typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} cssel_src_t;

   typedef enum logic [1:0] {ST_RUN, ST_WAIT_STABLE, ST_OLD_PAUSE, ST_NEW_PAUSE} cssel_state_t;

endpackage

// *** rtl/cssel_post_if.sv ***
// Interface between the selector and its internal oscillator postscaler.
`timescale 1ns/1ps
`default_nettype none
interface cssel_post_if;
   logic fast_tick;
   logic [2:0] ratio;
   logic div_tick;

   modport sel
   (
      output fast_tick,
      output ratio,
      input div_tick
   );

   modport post
   (
      input fast_tick,
      input ratio,
      output div_tick
   );
endinterface
`default_nettype wire

// *** rtl/cssel_postscaler.sv ***
// Postscaler that derives the divided internal frequencies from the fast oscillator.
`timescale 1ns/1ps
`default_nettype none
module cssel_postscaler
(
   input wire logic i_clk_sys, // System clock.
   input wire logic i_rst_n, // Synchronous reset, active low.
   cssel_post_if.post post // Fast tick in, divided tick out.
);

   logic [cssel_pkg::POST_W-1:0] cnt_q;
   logic [cssel_pkg::POST_W-1:0] mask;

   // ****************************************************************
   // Free-running divider
   // ****************************************************************
   // The counter only advances on fast oscillator ticks.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         cnt_q <= '0;
      else if (post.fast_tick)
         cnt_q <= cnt_q + 8'h01;
   end

   // Each ratio code picks a divide-by mask; the code is decoded
   // combinationally so a new ratio takes effect on the next tick.
   always_comb
   begin
      unique case (post.ratio)
         3'h7: mask = 8'h00;
         3'h6: mask = 8'h01;
         3'h5: mask = 8'h03;
         3'h4: mask = 8'h07;
         3'h3: mask = 8'h0F;
         3'h2: mask = 8'h1F;
         3'h1: mask = 8'h3F;
         3'h0: mask = 8'hFF;
      endcase
   end

   assign post.div_tick = post.fast_tick && ((cnt_q & mask) == mask);

endmodule
`default_nettype wire

// *** rtl/cssel_top.sv ***
// System clock source selector with glitch-free switching between oscillators.
//
// How it works
// RULE_01 - Two-bit field picks primary, secondary, internal source.
// RULE_02 - Every reset clears the source-select bits.
// RULE_03 - Three-bit field picks internal block output frequency.
// RULE_04 - Frequency field change acts immediately on internal output.
// RULE_05 - Reset sets internal block to default frequency.
// RULE_06 - Lowest code with source bit set uses postscaler.
// RULE_07 - Lowest code, bit clear: RC clock, fast off.
// RULE_08 - Watchdog and monitor always clocked from RC.
// RULE_09 - Primary flag after start-up timers, primary active.
// RULE_10 - Internal flag when block stable and active.
// RULE_11 - Secondary flag while secondary oscillator drives clock.
// RULE_12 - At most one source status flag set.
// RULE_13 - No flags for RC clock or unstable block.
// RULE_14 - Sleep instruction: sleep or idle by enable bit.
// RULE_15 - Secondary select ignored unless its oscillator enabled.
// RULE_16 - Software starts secondary oscillator before selecting it.
// RULE_17 - Switch pauses two old plus three new cycles.
// RULE_18 - Unstable new source: stay on old until stable.
`timescale 1ns/1ps
`default_nettype none
module cssel_top
(
   input wire logic i_clk_sys, // System clock, 100 MHz.
   input wire logic i_rst_n, // Synchronous reset, active low.
   input wire logic [3:0] i_addr, // Register address.
   input wire logic [7:0] i_wdata, // Register write data.
   input wire logic i_wr, // Write strobe.
   input wire logic i_rd, // Read strobe.
   output logic [7:0] o_rdata, // Read data, valid the cycle after the strobe.
   input wire logic [3:0] i_primary_osc_config, // Primary oscillator configuration bits.
   input wire logic i_pll_en, // PLL is enabled for the primary source.
   input wire logic i_prim_tick, // One cycle per primary oscillator period.
   input wire logic i_prim_ready, // Oscillator start-up timer has expired.
   input wire logic i_pll_ready, // PLL start-up timer has expired.
   input wire logic i_sec_tick, // One cycle per secondary oscillator period.
   input wire logic i_sec_stable, // Secondary oscillator is running and stable.
   input wire logic i_lprc_tick, // One cycle per low-power RC period.
   input wire logic i_fast_tick, // One cycle per fast internal oscillator period.
   input wire logic i_fast_stable, // Fast internal oscillator has stabilized.
   input wire logic i_sleep_exec, // Sleep instruction executed, one-cycle pulse.
   output logic o_sys_tick, // System clock tick after the switch gate.
   output logic o_clk_paused, // System clock held during a handover.
   output logic o_wdt_tick, // Watchdog tick from the RC oscillator.
   output logic o_fscm_tick, // Fail-safe monitor tick from the RC oscillator.
   output logic o_fast_osc_en, // Enable of the fast internal oscillator.
   output logic o_sec_osc_en, // Enable of the secondary oscillator.
   output logic o_sleep_enter, // Pulse: enter full sleep.
   output logic o_idle_enter, // Pulse: enter an idle mode.
   output logic [1:0] o_active_src // Source now driving the system clock.
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic idle_enable_q;
   logic [2:0] internal_freq_sel_q;
   logic [1:0] system_clock_source_sel_q;
   logic [7:0] osc_tuning_reg_q;
   logic [7:0] secondary_timer_ctrl_reg_q;
   logic [3:0] primary_osc_config_q;
   logic primary_running_flag_q;
   logic internal_stable_flag_q;
   logic secondary_running_flag_q;
   logic [7:0] rdata_q;
   logic sys_tick_q;
   logic wdt_tick_q;
   logic sleep_q;
   logic idle_q;
   logic [1:0] cnt_q;
   logic low_freq_source_sel;
   logic secondary_osc_enable;
   logic lprc_supplies;
   logic int_tick;
   logic int_stable;
   logic req_stable;
   logic old_tick;
   logic new_tick;
   logic running;
   logic wr_ctrl;
   logic [1:0] scs_wr;
   cssel_pkg::cssel_src_t req_src;
   cssel_pkg::cssel_src_t cur_q;
   cssel_pkg::cssel_src_t tgt_q;
   cssel_pkg::cssel_state_t state_q;

   cssel_post_if post_bus ();

   // ****************************************************************
   // Internal oscillator block
   // ****************************************************************
   // The postscaler sees the frequency field directly, so a write is
   // felt on the very next fast tick with no handover pause.
   assign post_bus.fast_tick = i_fast_tick;
   assign post_bus.ratio = internal_freq_sel_q; // RULE_04

   cssel_postscaler u_post
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n (i_rst_n),
      .post (post_bus.post)
   );

   assign low_freq_source_sel = osc_tuning_reg_q[cssel_pkg::BIT_LF_SRC];
   assign secondary_osc_enable = secondary_timer_ctrl_reg_q[cssel_pkg::BIT_SEC_OSC_EN];

   // At the lowest code the RC oscillator supplies the block unless the
   // postscaler path was chosen.
   assign lprc_supplies = (internal_freq_sel_q == cssel_pkg::IFREQ_LOW) &&
                          !low_freq_source_sel; // RULE_07

   // Block output: RC ticks on the RC path, or postscaled fast ticks otherwise.
   assign int_tick = lprc_supplies ? i_lprc_tick : post_bus.div_tick; // RULE_03 RULE_06

   // The RC path is always ready; the fast path needs its oscillator settled.
   assign int_stable = lprc_supplies || i_fast_stable;

   // ****************************************************************
   // Source request decode
   // ****************************************************************
   // Any code with the high bit set selects the internal block.
   always_comb
   begin
      if (system_clock_source_sel_q[1])
         req_src = cssel_pkg::SRC_INTERNAL;
      else if (system_clock_source_sel_q[0])
         req_src = cssel_pkg::SRC_SECONDARY;
      else
         req_src = cssel_pkg::SRC_PRIMARY;
   end // RULE_01

   // Primary readiness includes the PLL timer only when the PLL is used.
   always_comb
   begin
      unique case (req_src)
         cssel_pkg::SRC_PRIMARY: req_stable = i_prim_ready && (i_pll_ready || !i_pll_en);
         cssel_pkg::SRC_SECONDARY: req_stable = i_sec_stable;
         default: req_stable = int_stable;
      endcase
   end

   // Tick of the source now running and of the source being switched to.
   always_comb
   begin
      unique case (cur_q)
         cssel_pkg::SRC_PRIMARY: old_tick = i_prim_tick;
         cssel_pkg::SRC_SECONDARY: old_tick = i_sec_tick;
         default: old_tick = int_tick;
      endcase
      unique case (tgt_q)
         cssel_pkg::SRC_PRIMARY: new_tick = i_prim_tick;
         cssel_pkg::SRC_SECONDARY: new_tick = i_sec_tick;
         default: new_tick = int_tick;
      endcase
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   assign wr_ctrl = i_wr && (i_addr == cssel_pkg::OFS_OSC_CTRL);
   assign scs_wr = i_wdata[cssel_pkg::BIT_SCS_LO +: 2];

   // A request for the secondary source is dropped, leaving the field as
   // it was, when its oscillator is not enabled. Software is expected to
   // have that oscillator settled first; if not, the switch logic waits.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         system_clock_source_sel_q <= cssel_pkg::SCS_RST; // RULE_02
      else if (wr_ctrl && !((scs_wr == cssel_pkg::SCS_SECONDARY) && !secondary_osc_enable))
         system_clock_source_sel_q <= scs_wr; // RULE_15 RULE_16
   end

   // Frequency field and idle enable share the control register.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         internal_freq_sel_q <= cssel_pkg::IFREQ_RST; // RULE_05
         idle_enable_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         internal_freq_sel_q <= i_wdata[cssel_pkg::BIT_IFREQ_LO +: 3]; // RULE_03
         idle_enable_q <= i_wdata[cssel_pkg::BIT_IDLE_EN];
      end
   end

   // Tuning register; the unused bit is kept at zero by the mask.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         osc_tuning_reg_q <= cssel_pkg::TUNE_RST;
      else if (i_wr && (i_addr == cssel_pkg::OFS_OSC_TUNE))
         osc_tuning_reg_q <= i_wdata & cssel_pkg::TUNE_WR_MASK; // RULE_06
   end

   // Secondary timer control; the running flag is not stored here.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         secondary_timer_ctrl_reg_q <= cssel_pkg::SEC_RST;
      else if (i_wr && (i_addr == cssel_pkg::OFS_SEC_TMR))
         secondary_timer_ctrl_reg_q <= i_wdata & cssel_pkg::SEC_WR_MASK;
   end

   // Configuration bits are captured after reset release, never under it.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         primary_osc_config_q <= 4'h0;
      else
         primary_osc_config_q <= i_primary_osc_config; // RULE_01
   end

   // ****************************************************************
   // Glitch-free switch sequencer
   // ****************************************************************
   // The handover waits in the old source until the new one is ready,
   // then holds the clock for two old cycles and three new cycles. A new
   // request made during the pause is served once the pause completes;
   // cutting a pause short could emit a runt clock.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         state_q <= cssel_pkg::ST_RUN;
         cur_q <= cssel_pkg::SRC_PRIMARY;
         tgt_q <= cssel_pkg::SRC_PRIMARY;
         cnt_q <= 2'h0;
      end
      else
      begin
         unique case (state_q)
            cssel_pkg::ST_RUN:
            begin
               if (req_src != cur_q)
               begin
                  tgt_q <= req_src;
                  cnt_q <= 2'h0;
                  state_q <= req_stable ? cssel_pkg::ST_OLD_PAUSE :
                                          cssel_pkg::ST_WAIT_STABLE; // RULE_18
               end
            end
            cssel_pkg::ST_WAIT_STABLE:
            begin
               if (req_src == cur_q)
                  state_q <= cssel_pkg::ST_RUN;
               else
               begin
                  tgt_q <= req_src;
                  if (req_stable)
                     state_q <= cssel_pkg::ST_OLD_PAUSE; // RULE_18
               end
            end
            cssel_pkg::ST_OLD_PAUSE:
            begin
               if (old_tick)
               begin
                  if (cnt_q == cssel_pkg::OLD_SRC_CYCLES - 2'h1)
                  begin
                     cnt_q <= 2'h0;
                     state_q <= cssel_pkg::ST_NEW_PAUSE; // RULE_17
                  end
                  else
                     cnt_q <= cnt_q + 2'h1;
               end
            end
            cssel_pkg::ST_NEW_PAUSE:
            begin
               if (new_tick)
               begin
                  if (cnt_q == cssel_pkg::NEW_SRC_CYCLES - 2'h1)
                  begin
                     cnt_q <= 2'h0;
                     cur_q <= tgt_q;
                     state_q <= cssel_pkg::ST_RUN; // RULE_17
                  end
                  else
                     cnt_q <= cnt_q + 2'h1;
               end
            end
         endcase
      end
   end

   assign running = (state_q == cssel_pkg::ST_RUN) || (state_q == cssel_pkg::ST_WAIT_STABLE);

   // The gated tick only passes old-source ticks while not paused.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         sys_tick_q <= 1'b0;
      else
         sys_tick_q <= running && old_tick; // RULE_17
   end

   // ****************************************************************
   // Clock-source status flags
   // ****************************************************************
   // Each flag needs its own source active and the clock not paused, so no
   // two can be high together.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         primary_running_flag_q <= 1'b0;
         internal_stable_flag_q <= 1'b0;
         secondary_running_flag_q <= 1'b0;
      end
      else
      begin
         primary_running_flag_q <= running && (cur_q == cssel_pkg::SRC_PRIMARY) &&
                                   i_prim_ready && (i_pll_ready || !i_pll_en); // RULE_09 RULE_12
         internal_stable_flag_q <= running && (cur_q == cssel_pkg::SRC_INTERNAL) &&
                                   !lprc_supplies && i_fast_stable; // RULE_10 RULE_13
         secondary_running_flag_q <= running && (cur_q == cssel_pkg::SRC_SECONDARY); // RULE_11
      end
   end

   // ****************************************************************
   // Always-on RC consumers and oscillator enables
   // ****************************************************************
   // Watchdog and monitor keep the RC clock whatever source bit is set.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         wdt_tick_q <= 1'b0;
      else
         wdt_tick_q <= i_lprc_tick; // RULE_08
   end

   // Stopping the fast oscillator only on the RC path saves current; any
   // other choice keeps it warm so a jump up in frequency is quick.
   assign o_fast_osc_en = !((cur_q == cssel_pkg::SRC_INTERNAL) && lprc_supplies &&
                            (state_q == cssel_pkg::ST_RUN) &&
                            (req_src == cssel_pkg::SRC_INTERNAL)); // RULE_07
   assign o_sec_osc_en = secondary_osc_enable;

   // ****************************************************************
   // Sleep instruction
   // ****************************************************************
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         sleep_q <= 1'b0;
         idle_q <= 1'b0;
      end
      else
      begin
         sleep_q <= i_sleep_exec && !idle_enable_q; // RULE_14
         idle_q <= i_sleep_exec && idle_enable_q; // RULE_14
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   // Read data stand only in the cycle after the strobe; unmapped
   // addresses and idle cycles return zero.
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         rdata_q <= 8'h00;
      else if (i_rd)
      begin
         unique case (i_addr)
            cssel_pkg::OFS_OSC_CTRL:
               rdata_q <= {idle_enable_q, internal_freq_sel_q, primary_running_flag_q,
                           internal_stable_flag_q, system_clock_source_sel_q};
            cssel_pkg::OFS_OSC_TUNE:
               rdata_q <= osc_tuning_reg_q;
            cssel_pkg::OFS_SEC_TMR:
               rdata_q <= secondary_timer_ctrl_reg_q |
                          {1'b0, secondary_running_flag_q, 6'h00};
            cssel_pkg::OFS_PRI_CFG:
               rdata_q <= {4'h0, primary_osc_config_q};
            default:
               rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_rdata = rdata_q;
   assign o_sys_tick = sys_tick_q;
   assign o_clk_paused = !running;
   assign o_wdt_tick = wdt_tick_q;
   assign o_fscm_tick = wdt_tick_q;
   assign o_sleep_enter = sleep_q;
   assign o_idle_enter = idle_q;
   assign o_active_src = cur_q;

endmodule
`default_nettype wire

// *** tb/cssel_assertions.sv ***
// Checker of the port behaviour of the clock source selector.
`timescale 1ns/1ps
`default_nettype none
module cssel_checker
(
   input wire logic i_clk_sys, // System clock.
   input wire logic i_rst_n, // Reset, active low.
   input wire logic [3:0] i_addr, // Register address.
   input wire logic [7:0] i_wdata, // Write data.
   input wire logic i_wr, // Write strobe.
   input wire logic i_lprc_tick, // RC tick.
   input wire logic i_sleep_exec, // Sleep pulse.
   input wire logic o_sys_tick, // System tick.
   input wire logic o_clk_paused, // Handover pause.
   input wire logic o_wdt_tick, // Watchdog tick.
   input wire logic o_fscm_tick, // Monitor tick.
   input wire logic o_fast_osc_en, // Fast enable.
   input wire logic o_sec_osc_en, // Secondary enable.
   input wire logic o_sleep_enter, // Sleep entry.
   input wire logic o_idle_enter, // Idle entry.
   input wire logic [1:0] o_active_src // Active source.
);
   // ****************************************************************
   // Checks on the system clock
   // ****************************************************************
   // Reset silences every check so stale values never fire one.
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   sequence s_pause_start;
      $rose(o_clk_paused);
   endsequence
   sequence s_pause_three;
      o_clk_paused [*3];
   endsequence
   property p_rc_ticks;
      i_lprc_tick |=> o_wdt_tick && o_fscm_tick;
   endproperty
   a_rc_ticks: assert property (p_rc_ticks) else $error("RC ticks lost");
   property p_sleep;
      i_sleep_exec |=> o_sleep_enter != o_idle_enter;
   endproperty
   a_sleep: assert property (p_sleep) else $error("No single sleep entry");
   // The tick output lags its source by one cycle, so a paused cycle
   // shows up as a missing tick in the cycle after it.
   property p_gate;
      o_clk_paused |=> !o_sys_tick;
   endproperty
   a_gate: assert property (p_gate) else $error("Tick during pause");
   property p_src_hold;
      $changed(o_active_src) |-> $past(o_clk_paused);
   endproperty
   a_src_hold: assert property (p_src_hold) else $error("Source moved unpaused");
   property p_pause_len;
      s_pause_start |-> s_pause_three;
   endproperty
   a_pause_len: assert property (p_pause_len) else $error("Pause too short");
   property p_pause_end;
      $fell(o_clk_paused) |-> o_active_src != $past(o_active_src);
   endproperty
   a_pause_end: assert property (p_pause_end) else $error("Pause end mistimed");
   property p_sec_en;
      (i_wr && i_addr == 4'h2) |=> o_sec_osc_en == $past(i_wdata[3]);
   endproperty
   a_sec_en: assert property (p_sec_en) else $error("Secondary enable wrong");
   property p_rst_val;
      $rose(i_rst_n) |-> o_active_src == 2'h0 && o_fast_osc_en && !o_clk_paused;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("Bad reset state");
endmodule
`default_nettype wire

// *** tb/cssel_bench.sv ***
// Self-checking bench of the clock source selector.
`timescale 1ns/1ps
`default_nettype none
module cssel_bench;
   logic i_clk_sys, i_rst_n, i_wr, i_rd, i_pll_en, i_prim_tick, i_prim_ready;
   logic i_pll_ready, i_sec_tick, i_sec_stable, i_lprc_tick, i_fast_tick;
   logic i_fast_stable, i_sleep_exec, fast_all;
   logic [3:0] i_addr, i_primary_osc_config;
   logic [7:0] i_wdata, o_rdata;
   logic o_sys_tick, o_clk_paused, o_wdt_tick, o_fscm_tick, o_fast_osc_en;
   logic o_sec_osc_en, o_sleep_enter, o_idle_enter;
   logic [1:0] o_active_src;
   int n_fail, samples_checked, cyc, c;
   cssel_top cssel_top_inst (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_primary_osc_config, .i_pll_en, .i_prim_tick, .i_prim_ready, .i_pll_ready, .i_sec_tick,
      .i_sec_stable, .i_lprc_tick, .i_fast_tick, .i_fast_stable, .i_sleep_exec, .o_sys_tick,
      .o_clk_paused, .o_wdt_tick, .o_fscm_tick, .o_fast_osc_en, .o_sec_osc_en, .o_sleep_enter,
      .o_idle_enter, .o_active_src);
   // ****************************************************************
   // Clock, oscillator ticks and hang guard
   // ****************************************************************
   initial
   begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   // Ticks are random; the fast one may be forced on so rate counts are exact.
   always @(posedge i_clk_sys)
   begin
      i_prim_tick <= 1'($urandom);
      i_sec_tick <= 1'($urandom);
      i_lprc_tick <= 1'($urandom);
      i_fast_tick <= fast_all | 1'($urandom);
      i_primary_osc_config <= fast_all ? 4'hA : 4'($urandom);
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_fail++;
         close_out();
      end
   end
   // Expected tick count in 512 fast ticks with the postscaler path.
   function automatic int exp_rate(input logic [2:0] code);
      return (code == 3'h0) ? 2 : (512 >> (7 - code));
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 chk(16'(o_rdata), 16'(e));
   endtask
   // The pause waits on random ticks, so the wait is bounded, not fixed.
   task automatic wait_src(input logic [1:0] s);
      int k;
      k = 0;
      while (o_active_src !== s && k < 2000)
      begin
         @(posedge i_clk_sys);
         k++;
      end
      #1 chk(16'(o_active_src), 16'(s));
   endtask
   task automatic count_ticks(output int n);
      n = 0;
      repeat (512)
      begin
         @(posedge i_clk_sys);
         #1 n += (o_sys_tick === 1'b1);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Main sequence of scenarios.
   initial
   begin
      {i_rst_n, i_wr, i_rd, i_pll_en, i_prim_tick, i_prim_ready, i_pll_ready} = '0;
      {i_sec_tick, i_sec_stable, i_lprc_tick, i_fast_tick, i_fast_stable} = '0;
      {i_sleep_exec, fast_all, i_addr, i_wdata, i_primary_osc_config} = '0;
      n_fail = 0;
      samples_checked = 0;
      cyc = 0;
      c = $urandom(32'h9576);
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rd(4'h0, 8'h40);
      rd(4'h9, 8'h00);
      wr(4'h0, 8'h41);
      rd(4'h0, 8'h40);
      wr(4'h2, 8'h08);
      wr(4'h0, 8'h41);
      repeat (40) @(posedge i_clk_sys);
      #1 chk(16'({o_active_src, o_clk_paused}), 16'h0);
      i_sec_stable <= 1'b1;
      wait_src(2'h1);
      rd(4'h2, 8'h48);
      rd(4'h0, 8'h41);
      i_fast_stable <= 1'b1;
      fast_all <= 1'b1;
      wr(4'h1, 8'h80);
      for (int f = 0; f < 8; f++)
      begin
         wr(4'h0, 8'(f << 4) | 8'h02);
         wait_src(2'h2);
         repeat (260) @(posedge i_clk_sys);
         count_ticks(c);
         chk(16'(c), 16'(exp_rate(3'(f))));
      end
      rd(4'h0, 8'h76);
      rd(4'h3, 8'h0A);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h02);
      repeat (4) @(posedge i_clk_sys);
      #1 chk(16'(o_fast_osc_en), 16'h0);
      rd(4'h0, 8'h02);
      {i_prim_ready, i_pll_en, i_pll_ready} <= 3'h7;
      wr(4'h0, 8'h40);
      wait_src(2'h0);
      rd(4'h0, 8'h48);
      for (int m = 0; m < 2; m++)
      begin
         wr(4'h0, 8'(m << 7) | 8'h40);
         i_sleep_exec <= 1'b1;
         @(posedge i_clk_sys);
         i_sleep_exec <= 1'b0;
         #1 chk(16'({o_idle_enter, o_sleep_enter}), 16'(m + 1));
      end
      // Random writes land on the stored bits only.
      repeat (8)
      begin
         c = $urandom;
         wr(4'h1, 8'(c));
         rd(4'h1, 8'(c) & 8'hBF);
         wr(4'h2, 8'(c >> 8));
         rd(4'h2, 8'(c >> 8) & 8'hBF);
      end
      wr(4'h0, 8'h72);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      rd(4'h0, 8'h48);
      close_out();
   end
endmodule
bind cssel_top cssel_checker cssel_checker_inst (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata,
   .i_wr, .i_lprc_tick, .i_sleep_exec, .o_sys_tick, .o_clk_paused, .o_wdt_tick, .o_fscm_tick,
   .o_fast_osc_en, .o_sec_osc_en, .o_sleep_enter, .o_idle_enter, .o_active_src);
`default_nettype wire
